// >>> common/delay_if.sv
// start/busy handshake between the sequencer and its delay timer
`timescale 1ns/1ps
interface delay_if;
  logic start;
  rst_seq_pkg::delay_len_t length;
  logic busy;
  modport ctrl (output start, output length, input busy);
  modport unit (input start, input length, output busy);
endinterface

// >>> common/rst_seq_consts.svh
// constant offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH
// register byte offsets on the apb bus
`define A_STATUS 12'h000
`define A_IRQ_STATUS 12'h004
`define A_IRQ_MASK 12'h008
`define A_CTRL 12'h00C
// status register field positions
`define ST_PDF 0
`define ST_TO 1
`define ST_RUN 2
`define ST_STATE_LO 3
// event bit positions, shared by irq status and irq mask
`define EV_PIN 0
`define EV_WDT 1
`define EV_WARM 2
`define EV_READY 3
// control register fields and reset value, irq mask reset value
`define CTRL_WDT_EN 0
`define CTRL_RESET 4'h1
`define MASK_RESET 4'h0
// timing counts in system clock cycles
`define SST_CYCLES 11'h400
`define OPT_LOAD_CYCLES 11'h010
// reset images handed to the rest of the core
`define PORT_RESET 8'hFF
`define BANK_RESET 8'h00
`define INTC_RESET 8'h00
`define CONVERTER_CONTROL_REG_RESET 8'h40
`define CONVERTER_CLOCK_SELECT_RESET 4'h4
`define RTC_DIVIDER_CONTROL_LOW_RESET 3'h7
`endif

// >>> common/rst_seq_pkg.sv
// types shared by the reset sequencer and its delay timer
package rst_seq_pkg;
  typedef enum logic [2:0] {
    ST_PINHOLD = 3'h0,
    ST_SEQ = 3'h1,
    ST_SST = 3'h2,
    ST_OPT = 3'h3,
    ST_RUN = 3'h4
  } seq_state_t;
  typedef logic [10:0] delay_len_t;
endpackage

// >>> hdl/reset_sequencer.sv
// reset source arbitration, start-up delays, reset flags and apb status for the core
// Function
// RULE1: pin reset in run or standby, and watchdog timeout in run, give full reset
// RULE2: watchdog timeout in standby gives warm reset clearing only pc and stack pointer
// RULE3: flags: power-up 0,0; pin run u,u; pin wake 0,1; wdt run 1,u; wdt wake 1,1
// RULE4: start-up timer holds execution for 1024 system clock cycles
// RULE5: power-up reset includes the start-up timer delay
// RULE6: pin reset skips the start-up delay unless it wakes from standby
// RULE7: every wake-up from standby applies the start-up delay
// RULE8: power-up, watchdog run reset and pin reset add an option load delay
// RULE9: full reset clears pc, disables interrupts, timer off, ports input, stack top, watchdog cleared
// RULE10: non-warm resets load port latches and direction registers with all ones
// RULE11: non-warm resets clear bank and interrupt control, load converter and divider defaults
// RULE12: non-power-up resets keep pointers, accumulator, table pointer; power-up leaves them undefined
// RULE13: non-warm resets invalidate timer counts, pwm duty and converter result
// RULE14: external pin release is synchronised so everything leaves reset on one edge
// RULE15: power-down flag set by standby entry, cleared by power-up or watchdog clear
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "rst_seq_consts.svh"
module reset_sequencer (
  // clock, power-up reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources and core events
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic in_standby,
  input wire logic wake_request,
  input wire logic standby_exec,
  input wire logic watchdog_clear_exec,
  // reset actions toward the core
  output logic core_hold,
  output logic full_reset,
  output logic warm_reset,
  output logic power_up_reset,
  output logic watchdog_clear,
  output logic counts_invalid,
  // reset images toward the register file
  output logic [7:0] port_latch_init,
  output logic [7:0] port_a_direction,
  output logic [7:0] bank_pointer,
  output logic [7:0] interrupt_control_0,
  output logic [7:0] interrupt_control_1,
  output logic [7:0] converter_control_reg,
  output logic [3:0] converter_clock_select,
  output logic [2:0] rtc_divider_control,
  // reset flags and interrupt
  output logic watchdog_timeout_flag,
  output logic powerdown_flag,
  output logic irq
);
  rst_seq_pkg::seq_state_t state;
  logic pin_meta, pin_sync;
  logic need_sst, need_opt;
  logic [3:0] ctrl, irq_mask, irq_status;
  logic [3:0] events;
  logic pin_low, wdt_hit, wake_hit;
  logic apb_done, apb_write, apb_read;
  logic dly_start;
  rst_seq_pkg::delay_len_t dly_length;
  delay_if dly ();

  // register decode shared by write and read paths
  function automatic logic [1:0] decode(input logic [11:0] a);
    case (a)
      `A_STATUS: decode = 2'h0;
      `A_IRQ_STATUS: decode = 2'h1;
      `A_IRQ_MASK: decode = 2'h2;
      `A_CTRL: decode = 2'h3;
      default: decode = 2'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `A_STATUS) || (a == `A_IRQ_STATUS) || (a == `A_IRQ_MASK) || (a == `A_CTRL);
  endfunction

  assign dly.start = dly_start;
  assign dly.length = dly_length;

  startup_delay_timer u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(dly)
  );

  // two-flop synchroniser on the pin; only pin_sync is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (ce) begin
      pin_meta <= external_reset_pin_n; // RULE14
      pin_sync <= pin_meta;
    end
  end

  assign pin_low = !pin_sync;
  // watchdog only acts in run and while software leaves it enabled
  assign wdt_hit = (state == rst_seq_pkg::ST_RUN) && watchdog_timeout && ctrl[`CTRL_WDT_EN] && !pin_low;
  assign wake_hit = (state == rst_seq_pkg::ST_RUN) && in_standby && wake_request && !pin_low && !wdt_hit;
  assign apb_done = psel && penable && pready;
  assign apb_write = apb_done && pwrite && mapped(paddr);
  assign apb_read = apb_done && !pwrite;

  // sequencer: pin hold, then start-up delay, then option load, then run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rst_seq_pkg::ST_SEQ;
      need_sst <= 1'b1; // RULE5
      need_opt <= 1'b1; // RULE8
      dly_start <= 1'b0;
      dly_length <= `SST_CYCLES;
    end else if (ce) begin
      dly_start <= 1'b0;
      if (pin_low && state != rst_seq_pkg::ST_PINHOLD) begin
        // pin wins over everything; a pending delay is restarted after release
        state <= rst_seq_pkg::ST_PINHOLD; // RULE1
        need_sst <= (state == rst_seq_pkg::ST_RUN) ? in_standby : need_sst; // RULE6
        need_opt <= 1'b1; // RULE8
      end else begin
        case (state)
          rst_seq_pkg::ST_PINHOLD: begin
            if (!pin_low) begin
              state <= rst_seq_pkg::ST_SEQ; // RULE14
            end
          end
          rst_seq_pkg::ST_SEQ: begin
            if (need_sst) begin
              dly_start <= 1'b1;
              dly_length <= `SST_CYCLES; // RULE4
              state <= rst_seq_pkg::ST_SST;
            end else if (need_opt) begin
              dly_start <= 1'b1;
              dly_length <= `OPT_LOAD_CYCLES; // RULE8
              state <= rst_seq_pkg::ST_OPT;
            end else begin
              state <= rst_seq_pkg::ST_RUN;
            end
          end
          rst_seq_pkg::ST_SST: begin
            if (!dly.busy) begin
              need_sst <= 1'b0;
              state <= rst_seq_pkg::ST_SEQ;
            end
          end
          rst_seq_pkg::ST_OPT: begin
            if (!dly.busy) begin
              need_opt <= 1'b0;
              state <= rst_seq_pkg::ST_SEQ;
            end
          end
          rst_seq_pkg::ST_RUN: begin
            if (wdt_hit) begin
              state <= rst_seq_pkg::ST_SEQ;
              need_sst <= in_standby; // RULE7
              need_opt <= !in_standby; // RULE8
            end else if (wake_hit) begin
              state <= rst_seq_pkg::ST_SEQ;
              need_sst <= 1'b1; // RULE7
            end
          end
          default: begin
            state <= rst_seq_pkg::ST_SEQ;
          end
        endcase
      end
    end
  end

  // reset action pulses and the core_hold level; warm reset touches only pc and stack pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reset <= 1'b1;
      warm_reset <= 1'b0;
      watchdog_clear <= 1'b1;
      counts_invalid <= 1'b1;
      core_hold <= 1'b1;
    end else if (ce) begin
      full_reset <= (pin_low && state == rst_seq_pkg::ST_RUN) || (wdt_hit && !in_standby); // RULE1 RULE9
      warm_reset <= wdt_hit && in_standby; // RULE2
      watchdog_clear <= (pin_low && state == rst_seq_pkg::ST_RUN) || (wdt_hit && !in_standby); // RULE9
      counts_invalid <= (pin_low && state == rst_seq_pkg::ST_RUN) || (wdt_hit && !in_standby); // RULE13
      // low only while the next state is run; any cause taken in run raises it at once
      core_hold <= !(events[`EV_READY] || (state == rst_seq_pkg::ST_RUN && !pin_low && !wdt_hit && !wake_hit));
    end
  end

  // power-up marker: data registers have no defined value until the first run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up_reset <= 1'b1; // RULE12
    end else if (ce) begin
      if (events[`EV_READY]) begin
        power_up_reset <= 1'b0;
      end
    end
  end

  // reset images; reloaded on every full reset and left alone by warm reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_init <= `PORT_RESET;
      port_a_direction <= `PORT_RESET;
      bank_pointer <= `BANK_RESET;
      interrupt_control_0 <= `INTC_RESET;
      interrupt_control_1 <= `INTC_RESET;
      converter_control_reg <= `CONVERTER_CONTROL_REG_RESET;
      converter_clock_select <= `CONVERTER_CLOCK_SELECT_RESET;
      rtc_divider_control <= `RTC_DIVIDER_CONTROL_LOW_RESET;
    end else if (ce) begin
      if ((pin_low && state == rst_seq_pkg::ST_RUN) || (wdt_hit && !in_standby)) begin
        port_latch_init <= `PORT_RESET; // RULE10
        port_a_direction <= `PORT_RESET; // RULE10
        bank_pointer <= `BANK_RESET; // RULE11
        interrupt_control_0 <= `INTC_RESET; // RULE11
        interrupt_control_1 <= `INTC_RESET; // RULE11
        converter_control_reg <= `CONVERTER_CONTROL_REG_RESET; // RULE11
        converter_clock_select <= `CONVERTER_CLOCK_SELECT_RESET; // RULE11
        rtc_divider_control <= `RTC_DIVIDER_CONTROL_LOW_RESET; // RULE11
      end
    end
  end

  // reset flags; the setting event wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag <= 1'b0; // RULE3
      powerdown_flag <= 1'b0; // RULE15
    end else if (ce) begin
      if (wdt_hit) begin
        watchdog_timeout_flag <= 1'b1; // RULE3
      end else if (pin_low && state == rst_seq_pkg::ST_RUN && in_standby) begin
        watchdog_timeout_flag <= 1'b0; // RULE3
      end else if (standby_exec && state == rst_seq_pkg::ST_RUN) begin
        watchdog_timeout_flag <= 1'b0;
      end
      if (standby_exec && state == rst_seq_pkg::ST_RUN) begin
        powerdown_flag <= 1'b1; // RULE15
      end else if (state == rst_seq_pkg::ST_RUN && in_standby && (wdt_hit || pin_low)) begin
        powerdown_flag <= 1'b1; // RULE3
      end else if (watchdog_clear_exec && state == rst_seq_pkg::ST_RUN) begin
        powerdown_flag <= 1'b0; // RULE15
      end
    end
  end

  // reset cause and ready events for the interrupt status
  assign events[`EV_PIN] = pin_low && state == rst_seq_pkg::ST_RUN;
  assign events[`EV_WDT] = wdt_hit && !in_standby;
  assign events[`EV_WARM] = wdt_hit && in_standby;
  assign events[`EV_READY] = state == rst_seq_pkg::ST_SEQ && !need_sst && !need_opt && !pin_low;

  // sticky status, cleared by a read; a new event in the read cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
    end else if (ce) begin
      if (apb_read && paddr == `A_IRQ_STATUS) begin
        irq_status <= events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  // level interrupt from unmasked status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_irq_bits(irq_status, events, apb_read && paddr == `A_IRQ_STATUS) & irq_mask);
    end
  end

  function automatic logic [3:0] next_irq_bits(input logic [3:0] s, input logic [3:0] e, input logic clr);
    next_irq_bits = clr ? e : (s | e);
  endfunction

  // software writable mask and control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `MASK_RESET;
      ctrl <= `CTRL_RESET;
    end else if (ce) begin
      if (apb_write && decode(paddr) == 2'h2) begin
        irq_mask <= pwdata[3:0];
      end
      if (apb_write && decode(paddr) == 2'h3) begin
        ctrl <= pwdata[3:0];
      end
    end
  end

  // apb answer: pready one cycle after setup, read data captured with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped(paddr);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && mapped(paddr)) begin
        case (decode(paddr))
          2'h0: prdata <= {26'h0, state, 1'b0 | (state == rst_seq_pkg::ST_RUN),
                           watchdog_timeout_flag, powerdown_flag};
          2'h1: prdata <= {28'h0000000, irq_status | events};
          2'h2: prdata <= {28'h0000000, irq_mask};
          2'h3: prdata <= {28'h0000000, ctrl};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // helper counter: busy cycles seen during the start-up delay
  logic [11:0] sst_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sst_seen <= 12'h000;
    end else if (ce) begin
      if (state != rst_seq_pkg::ST_SST) begin
        sst_seen <= 12'h000;
      end else if (dly.busy) begin
        sst_seen <= sst_seen + 12'h001;
      end
    end
  end

  sequence s_wdt_warm;
    ce && wdt_hit && in_standby;
  endsequence

  sequence s_wdt_full;
    ce && wdt_hit && !in_standby;
  endsequence

  a_sst_length: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (ce && state == rst_seq_pkg::ST_SST && !dly.busy) |-> sst_seen == 12'h400)
    else $error("start-up delay not 1024 cycles");

  a_warm_only_pc: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    s_wdt_warm |=> warm_reset && !full_reset && $stable(port_latch_init) && $stable(bank_pointer))
    else $error("warm reset touched more than pc and stack pointer");

  a_wdt_full_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    s_wdt_full |=> full_reset && watchdog_clear && counts_invalid && watchdog_timeout_flag)
    else $error("watchdog run timeout missed full reset");

  a_wake_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    s_wdt_warm |=> watchdog_timeout_flag && powerdown_flag)
    else $error("watchdog wake flags not 1,1");

  a_pin_no_sst: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (ce && state == rst_seq_pkg::ST_RUN && pin_low && !in_standby) |=> !need_sst)
    else $error("pin reset in run requested start-up delay");

  a_wake_sst: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (ce && wake_hit) |=> need_sst && state == rst_seq_pkg::ST_SEQ)
    else $error("wake-up without start-up delay");

  a_opt_before_run: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (ce && state == rst_seq_pkg::ST_SEQ && need_opt && !need_sst && !pin_low) |=> state == rst_seq_pkg::ST_OPT)
    else $error("option load delay skipped");

  a_ports_reload: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    s_wdt_full |=> port_latch_init == `PORT_RESET && port_a_direction == `PORT_RESET
      && converter_control_reg == `CONVERTER_CONTROL_REG_RESET)
    else $error("reset images not reloaded");

  a_pdf_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (ce && standby_exec && state == rst_seq_pkg::ST_RUN) |=> powerdown_flag)
    else $error("power-down flag not set on standby entry");

  a_hold_sync: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (ce && pin_low && state == rst_seq_pkg::ST_RUN) |=> ##1 core_hold)
    else $error("core not held after pin reset");
endmodule

// >>> hdl/startup_delay_timer.sv
// down counter that holds busy for a programmed number of cycles
`timescale 1ns/1ps
module startup_delay_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control handshake
  delay_if.unit d
);
  rst_seq_pkg::delay_len_t count;

  // load length-1 on start; busy covers the start cycle too, so busy lasts exactly length cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 11'h000;
    end else if (ce) begin
      if (d.start) begin
        count <= d.length - 11'h001;
      end else if (count != 11'h000) begin
        count <= count - 11'h001;
      end
    end
  end

  assign d.busy = d.start | (count != 11'h000);
endmodule

// >>> tb/reset_pin_driver.sv
// behavioural model of the external reset circuit that drives the reset pin
`timescale 1ns/1ps
module reset_pin_driver (
  // clock of the pressing circuit
  input wire logic pclk,
  // reset pin, pulled up while released
  output logic pin_n
);
  // the pin idles at its pull-up level
  initial begin
    pin_n = 1'b1;
  end

  // hold the pin low for a number of cycles, then let the pull-up take it high again
  task automatic press(input int cycles);
    @(posedge pclk);
    pin_n <= 1'b0;
    repeat (cycles) @(posedge pclk);
    pin_n <= 1'b1;
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking testbench of the reset sequencer, register access over apb
`timescale 1ns/1ps
`include "rst_seq_consts.svh"
module testbench;
  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, pin_n, wdt_to, in_standby, wake_req, stby_exec, wclr_exec;
  logic core_hold, full_reset, warm_reset, power_up_reset, wdt_clear, counts_invalid, to_flag, pd_flag, irq;
  logic [7:0] latch_i, dir_i, bank_i, ic0_i, ic1_i, adc_i;
  logic [3:0] acs_i;
  logic [2:0] rtc_i;
  logic saw_full, saw_warm, err;
  int failures, n_checks, n;

  // clock and clock enable; ce stays high, freezing is not exercised
  initial begin
    pclk = 1'b0;
  end
  always #12.5 pclk = ~pclk;

  reset_pin_driver rst_drv (.pclk(pclk), .pin_n(pin_n));

  reset_sequencer dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(pin_n), .watchdog_timeout(wdt_to), .in_standby(in_standby),
    .wake_request(wake_req), .standby_exec(stby_exec), .watchdog_clear_exec(wclr_exec),
    .core_hold(core_hold), .full_reset(full_reset), .warm_reset(warm_reset),
    .power_up_reset(power_up_reset), .watchdog_clear(wdt_clear), .counts_invalid(counts_invalid),
    .port_latch_init(latch_i), .port_a_direction(dir_i), .bank_pointer(bank_i),
    .interrupt_control_0(ic0_i), .interrupt_control_1(ic1_i), .converter_control_reg(adc_i),
    .converter_clock_select(acs_i), .rtc_divider_control(rtc_i),
    .watchdog_timeout_flag(to_flag), .powerdown_flag(pd_flag), .irq(irq)
  );

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i >= 20) begin
      failures++;
      final_report();
    end
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle pulse on a core event input
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: wdt_to <= 1'b1;
      1: stby_exec <= 1'b1;
      2: wclr_exec <= 1'b1;
      default: wake_req <= 1'b1;
    endcase
    @(posedge pclk);
    {wdt_to, stby_exec, wclr_exec, wake_req} <= 4'h0;
  endtask

  // count cycles of core_hold high; bounded so a stuck hold ends the run
  task automatic hold_len();
    int i;
    n = 0;
    saw_full = 1'b0;
    saw_warm = 1'b0;
    for (i = 0; i < 3000 && !(n > 0 && core_hold === 1'b0); i++) begin
      @(posedge pclk);
      #1;
      if (full_reset === 1'b1) saw_full = 1'b1;
      if (full_reset === 1'b1) check({30'h0, wdt_clear, counts_invalid}, 32'h3);
      if (warm_reset === 1'b1) saw_warm = 1'b1;
      if (core_hold === 1'b1) n++;
    end
    if (i >= 3000) begin
      failures++;
      final_report();
    end
  endtask

  task automatic flags(input logic [1:0] exp);
    check(32'({to_flag, pd_flag}), 32'(exp));
  endtask

  initial begin
    {ce, presetn} = 2'h2;
    {psel, penable, pwrite, wdt_to, in_standby, wake_req, stby_exec, wclr_exec} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // power-up: start-up delay plus option load, flags cleared
    hold_len();
    check(32'(n >= 1040 && n <= 1060), 32'h1);
    check(32'(power_up_reset), 32'h0);
    flags(2'h0);
    check({latch_i, dir_i, bank_i, ic0_i}, 32'hFFFF0000);
    check({ic1_i, adc_i, 4'h0, acs_i, 5'h00, rtc_i}, 32'h00400407);
    // register access, including an unmapped address and read-to-clear status
    apb(1'b0, `A_CTRL, 32'h0);
    check(d, 32'h1);
    apb(1'b1, `A_IRQ_MASK, 32'hF);
    apb(1'b0, `A_IRQ_MASK, 32'h0);
    check(d, 32'hF);
    apb(1'b0, 12'h010, 32'h0);
    check({err, d[30:0]}, 32'h80000000);
    apb(1'b0, `A_IRQ_STATUS, 32'h0);
    apb(1'b0, `A_IRQ_STATUS, 32'h0);
    check(d, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    // standby instruction sets power-down and clears time-out
    pulse(1);
    repeat (2) @(posedge pclk);
    flags(2'h1);
    // pin reset in run: no start-up delay, option load only, flags unchanged
    // press runs alongside so the one-cycle reset pulses fall inside the watch
    fork
      rst_drv.press(6);
    join_none
    hold_len();
    check(32'(n >= 16 && n <= 40), 32'h1);
    check(32'(saw_full), 32'h1);
    flags(2'h1);
    check(32'(irq), 32'h1);
    apb(1'b0, `A_IRQ_STATUS, 32'h0);
    check(32'(d[`EV_PIN]), 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(irq), 32'h0);
    // watchdog timeout in run: full reset, time-out set, power-down kept
    fork
      pulse(0);
    join_none
    hold_len();
    check(32'(n >= 16 && n <= 40), 32'h1);
    check(32'(saw_full), 32'h1);
    flags(2'h3);
    // watchdog clear instruction clears power-down only
    pulse(2);
    repeat (2) @(posedge pclk);
    flags(2'h2);
    // watchdog timeout in standby: warm reset with start-up delay
    pulse(1);
    in_standby <= 1'b1;
    fork
      pulse(0);
    join_none
    hold_len();
    in_standby <= 1'b0;
    check(32'(n >= 1024 && n <= 1050), 32'h1);
    check({31'h0, saw_full}, 32'h0);
    check(32'(saw_warm), 32'h1);
    flags(2'h3);
    apb(1'b0, `A_STATUS, 32'h0);
    check(32'(d[1:0]), 32'h3);
    // pin wake from standby: full reset with start-up delay
    pulse(1);
    in_standby <= 1'b1;
    fork
      rst_drv.press(6);
    join_none
    hold_len();
    in_standby <= 1'b0;
    check(32'(n >= 1024 && n <= 1070), 32'h1);
    check(32'(saw_full), 32'h1);
    flags(2'h1);
    // plain wake request from standby still waits out the start-up delay
    pulse(1);
    in_standby <= 1'b1;
    fork
      pulse(3);
    join_none
    hold_len();
    in_standby <= 1'b0;
    check(32'(n >= 1024 && n <= 1050), 32'h1);
    check(32'(saw_full), 32'h0);
    check(32'(saw_warm), 32'h0);
    // watchdog disabled: a timeout is ignored
    apb(1'b1, `A_CTRL, 32'h0);
    pulse(0);
    repeat (6) @(posedge pclk);
    check(32'(core_hold), 32'h0);
    // second power-up in mid-run clears both flags
    pulse(1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    flags(2'h0);
    check(32'(power_up_reset), 32'h1);
    presetn <= 1'b1;
    hold_len();
    check(32'(n >= 1040 && n <= 1060), 32'h1);
    final_report();
  end
endmodule
